// [rtl/tunable_timer_pkg.sv]
package tunable_timer_pkg;
    // Sizes of the block
    localparam int NUM_TMR = 3;
    localparam int NUM_CTRL = 2;
    localparam int PINS_PER_CTRL = 20;
    localparam int NUM_PINS = NUM_CTRL * PINS_PER_CTRL;
    // Nanosecond limits of a timer word
    localparam logic [29:0] NS_MAX = 30'h3b9ac9ff;
    localparam logic [29:0] NS_PER_SEC = 30'h3b9aca00;
    // Per-tick step in units of 2^-32 ns
    localparam int TMT_PERIOD_NS = 5;
    localparam logic [63:0] ONE_NS = 64'h0000_0001_0000_0000;
    localparam logic [63:0] HALF_NS = 64'h0000_0000_8000_0000;
    localparam logic [63:0] STEP_BASE = 64'(TMT_PERIOD_NS) << 32;
    localparam logic [63:0] STEP_MIN = STEP_BASE - ONE_NS - HALF_NS;
    localparam logic [63:0] STEP_MAX = STEP_BASE + ONE_NS + HALF_NS;
    // Register byte offsets
    localparam logic [11:0] OFS_SUBNS = 12'h000;
    localparam logic [11:0] OFS_NS = 12'h004;
    localparam logic [11:0] OFS_SEC = 12'h008;
    localparam logic [11:0] OFS_INC = 12'h00c;
    localparam logic [11:0] OFS_ADJ = 12'h030;
    localparam logic [11:0] OFS_RAW = 12'h040;
    localparam logic [11:0] OFS_MASK = 12'h044;
    localparam logic [11:0] OFS_MIS = 12'h048;
    localparam logic [11:0] OFS_SNAPC = 12'h050;
    localparam logic [11:0] OFS_SNAPS = 12'h054;
    localparam logic [11:0] OFS_XT_NS = 12'h058;
    localparam logic [11:0] OFS_XT_SEC = 12'h05c;
    localparam logic [11:0] OFS_XT_ARTL = 12'h060;
    localparam logic [11:0] OFS_XT_ARTH = 12'h064;
    localparam logic [11:0] OFS_CMP_LO = 12'h068;
    localparam logic [11:0] OFS_CMP_HI = 12'h06c;
    localparam logic [11:0] OFS_PIV_LO = 12'h070;
    localparam logic [11:0] OFS_PIV_HI = 12'h074;
    localparam logic [11:0] OFS_VIEW = 12'h078;
    localparam logic [11:0] OFS_VIEW_LO = 12'h07c;
    localparam logic [11:0] OFS_VIEW_HI = 12'h080;
    localparam logic [11:0] OFS_PIN = 12'h100;
    // Field positions
    localparam int PC_EN_BIT = 0;
    localparam int INC_SIGN_BIT = 31;
    localparam int ADJ_SIGN_BIT = 31;
    localparam int CMP_HIT_BIT = 3;
    localparam logic [5:0] SNAP_BITS = 6'h15;
    localparam logic [1:0] SRC_ART = 2'h0;
    // Bus phase states, Gray along idle, read, read-out
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_READ = 2'b01,
        BUS_RDOUT = 2'b11,
        BUS_WRITE = 2'b10
    } bus_state_t;
endpackage : tunable_timer_pkg

// [rtl/tunable_time_base_timer.sv]
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module tunable_time_base_timer (
    input wire logic clk, // System clock, one timer tick
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Word transfers only
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic hreadyout, // Slave ready
    output logic [31:0] hrdata, // Read data
    output logic hresp, // Always OKAY
    input wire logic art_tick, // Crystal-rate enable pulse
    output logic [39:0] pin_enable, // Per-pin enable
    output logic [39:0] pin_art_clock, // Pin runs on crystal rate
    output logic irq // Coalesced interrupt
);
    typedef struct packed {
        tunable_timer_pkg::bus_state_t bst; // Bus phase
        logic [11:0] addr; // Latched address
        logic [31:0] rdata; // Read data register
        logic [2:0][31:0] subns; // Sub-ns fraction
        logic [2:0][29:0] ns; // Nanoseconds
        logic [2:0][31:0] sec; // Seconds
        logic [2:0][29:0] snap_ns; // Read snapshot ns
        logic [2:0][31:0] snap_sec; // Read snapshot seconds
        logic [2:0][31:0] inc; // Increment attributes
        logic [2:0][29:0] adj; // Remaining offset adjust
        logic [2:0] adj_neg; // Adjust direction
        logic [3:0] raw; // Raw interrupt status
        logic [3:0] mask; // Interrupt mask control
        logic irq; // Registered interrupt
        logic [5:0] snap_req; // Pending capture request
        logic [5:0] snap_ok; // Capture valid flags
        logic [29:0] xt_ns; // Captured timer ns
        logic [31:0] xt_sec; // Captured timer seconds
        logic [63:0] always_running_counter; // Always-running counter
        logic [63:0] xt_art; // Captured counter
        logic [29:0] cmp_ns; // Compare nanoseconds
        logic [31:0] cmp_sec; // Compare seconds
        logic [29:0] piv_ns; // Interval nanoseconds
        logic [31:0] piv_sec; // Interval seconds
        logic [5:0] view; // Pin chosen for readback
        logic [39:0][2:0] pinctl; // Pin control registers
    } state_t;

    state_t st_r; // Registered state
    state_t st_nxt; // Next state
    logic wr_go; // Write data phase
    logic rd_go; // Read data phase

    // Step of one tick, in units of 2^-32 ns
    function automatic logic [63:0] tmr_step(
        input logic [31:0] inc,
        input logic adj_on,
        input logic adj_neg
    );
        logic [63:0] s;
        s = tunable_timer_pkg::STEP_BASE;
        // Magnitude kept below half a ns so the timer never runs back
        if (inc[tunable_timer_pkg::INC_SIGN_BIT]) begin
            s = s - {33'h0, inc[30:0]};
        end else begin
            s = s + {33'h0, inc[30:0]};
        end
        if (adj_on) begin
            if (adj_neg) begin
                s = s - tunable_timer_pkg::ONE_NS;
            end else begin
                s = s + tunable_timer_pkg::ONE_NS;
            end
        end
        return s;
    endfunction : tmr_step

    // Fold a nanosecond overflow into seconds, returns {sec, ns}
    function automatic logic [61:0] cmp_norm(
        input logic [30:0] ns,
        input logic [31:0] sec
    );
        logic [30:0] d;
        d = ns - {1'b0, tunable_timer_pkg::NS_PER_SEC};
        if (ns > {1'b0, tunable_timer_pkg::NS_MAX}) begin
            return {sec + 32'h1, d[29:0]};
        end
        return {sec, ns[29:0]};
    endfunction : cmp_norm

    assign wr_go = (st_r.bst == tunable_timer_pkg::BUS_WRITE);
    assign rd_go = (st_r.bst == tunable_timer_pkg::BUS_READ);

    // Next-state logic for the whole block
    always_comb begin
        state_t n;
        logic [63:0] acc;
        logic [3:0] raw_set;
        logic [3:0] raw_clr;
        logic [31:0] rd;
        logic [11:0] a;
        logic [5:0] pidx;
        logic [1:0] t;
        logic [2:0] pc;
        logic [61:0] cn;
        n = st_r;
        acc = 64'h0;
        raw_set = 4'h0;
        raw_clr = 4'h0;
        rd = 32'h0;
        a = st_r.addr;
        pidx = a[7:2];
        t = a[5:4];
        pc = 3'h0;
        cn = 62'h0;
        // Timers advance every tick, adjust drains 1 ns a tick
        for (int i = 0; i < tunable_timer_pkg::NUM_TMR; i++) begin
            acc = {2'b00, st_r.ns[i], st_r.subns[i]}
                + tmr_step(st_r.inc[i], st_r.adj[i] != 30'h0,
                           st_r.adj_neg[i]);
            // Fraction carries into ns; ns wraps into seconds
            if (acc[63:32] > {2'b00, tunable_timer_pkg::NS_MAX}) begin
                acc[63:32] = acc[63:32]
                    - {2'b00, tunable_timer_pkg::NS_PER_SEC};
                n.sec[i] = st_r.sec[i] + 32'h1;
            end
            n.subns[i] = acc[31:0];
            n.ns[i] = acc[61:32];
            if (st_r.adj[i] != 30'h0) begin
                n.adj[i] = st_r.adj[i] - 30'h1;
                if (st_r.adj[i] == 30'h1) begin
                    raw_set[i] = 1'b1;
                end
            end
        end
        // Local counter ticks at the crystal rate
        if (art_tick) begin
            n.always_running_counter = st_r.always_running_counter + 64'h1;
        end
        // Periodic compare against timer 0, reloaded by the interval
        if ({st_r.sec[0], st_r.ns[0]} >= {st_r.cmp_sec, st_r.cmp_ns}) begin
            raw_set[tunable_timer_pkg::CMP_HIT_BIT] = 1'b1;
            n.cmp_sec = st_r.cmp_sec + st_r.piv_sec;
            cn = cmp_norm({1'b0, st_r.cmp_ns} + {1'b0, st_r.piv_ns},
                          n.cmp_sec);
            n.cmp_sec = cn[61:30];
            n.cmp_ns = cn[29:0];
        end
        // Capture one timer with the counter, lowest request first
        if (st_r.snap_req != 6'h0) begin
            for (int i = tunable_timer_pkg::NUM_TMR - 1; i >= 0; i--) begin
                if (st_r.snap_req[2 * i]) begin
                    n.xt_ns = st_r.ns[i];
                    n.xt_sec = st_r.sec[i];
                    n.snap_ok = 6'h0;
                    n.snap_ok[2 * i] = 1'b1;
                end
            end
            n.xt_art = st_r.always_running_counter;
            n.snap_req = 6'h0;
        end
        // Register writes override the running update, except raw flag clears
        if (wr_go) begin
            if (a < tunable_timer_pkg::OFS_ADJ) begin
                // Sub-ns word writes are dropped
                case (a[3:0])
                    tunable_timer_pkg::OFS_NS[3:0]: begin
                        n.ns[t] = hwdata[29:0];
                    end
                    tunable_timer_pkg::OFS_SEC[3:0]: begin
                        n.sec[t] = hwdata;
                    end
                    tunable_timer_pkg::OFS_INC[3:0]: begin
                        n.inc[t] = hwdata;
                    end
                    default: begin
                    end
                endcase
            end else if (a >= tunable_timer_pkg::OFS_PIN) begin
                if (a < tunable_timer_pkg::OFS_PIN + 12'h0a0) begin
                    n.pinctl[pidx] = hwdata[2:0];
                end
            end else begin
                case (a)
                    tunable_timer_pkg::OFS_ADJ,
                    tunable_timer_pkg::OFS_ADJ + 12'h004,
                    tunable_timer_pkg::OFS_ADJ + 12'h008: begin
                        n.adj[a[3:2]] = hwdata[29:0];
                        n.adj_neg[a[3:2]] =
                            hwdata[tunable_timer_pkg::ADJ_SIGN_BIT];
                    end
                    tunable_timer_pkg::OFS_RAW: begin
                        raw_clr = hwdata[3:0];
                    end
                    tunable_timer_pkg::OFS_MASK: begin
                        n.mask = hwdata[3:0];
                    end
                    tunable_timer_pkg::OFS_SNAPC: begin
                        n.snap_req = hwdata[5:0]
                            & tunable_timer_pkg::SNAP_BITS;
                        n.snap_ok = 6'h0;
                    end
                    tunable_timer_pkg::OFS_CMP_LO: begin
                        // Bits 31:30 are ignored
                        cn = cmp_norm({1'b0, hwdata[29:0]},
                                      st_r.cmp_sec);
                        n.cmp_sec = cn[61:30];
                        n.cmp_ns = cn[29:0];
                    end
                    tunable_timer_pkg::OFS_CMP_HI: begin
                        n.cmp_sec = hwdata;
                    end
                    tunable_timer_pkg::OFS_PIV_LO: begin
                        n.piv_ns = hwdata[29:0];
                    end
                    tunable_timer_pkg::OFS_PIV_HI: begin
                        n.piv_sec = hwdata;
                    end
                    tunable_timer_pkg::OFS_VIEW: begin
                        n.view = hwdata[5:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
        // Read data is built from registered state one cycle late
        if (rd_go) begin
            if (a < tunable_timer_pkg::OFS_ADJ) begin
                case (a[3:0])
                    tunable_timer_pkg::OFS_SUBNS[3:0]: begin
                        rd = st_r.subns[t];
                        n.snap_ns[t] = st_r.ns[t];
                        n.snap_sec[t] = st_r.sec[t];
                    end
                    tunable_timer_pkg::OFS_NS[3:0]: begin
                        rd = {2'b00, st_r.snap_ns[t]};
                    end
                    tunable_timer_pkg::OFS_SEC[3:0]: begin
                        rd = st_r.snap_sec[t];
                    end
                    default: begin
                        rd = st_r.inc[t];
                    end
                endcase
            end else if (a >= tunable_timer_pkg::OFS_PIN) begin
                if (a < tunable_timer_pkg::OFS_PIN + 12'h0a0) begin
                    rd = {29'h0, st_r.pinctl[pidx]};
                end
            end else begin
                pc = (st_r.view < 6'd40) ? st_r.pinctl[st_r.view] : 3'h0;
                case (a)
                    tunable_timer_pkg::OFS_ADJ,
                    tunable_timer_pkg::OFS_ADJ + 12'h004,
                    tunable_timer_pkg::OFS_ADJ + 12'h008: begin
                        rd = {st_r.adj_neg[a[3:2]], 1'b0, st_r.adj[a[3:2]]};
                    end
                    tunable_timer_pkg::OFS_RAW: rd = {28'h0, st_r.raw};
                    tunable_timer_pkg::OFS_MASK: rd = {28'h0, st_r.mask};
                    tunable_timer_pkg::OFS_MIS: begin
                        rd = {28'h0, st_r.raw & st_r.mask};
                    end
                    tunable_timer_pkg::OFS_SNAPC: begin
                        rd = {26'h0, st_r.snap_req};
                    end
                    tunable_timer_pkg::OFS_SNAPS: begin
                        rd = {26'h0, st_r.snap_ok};
                    end
                    tunable_timer_pkg::OFS_XT_NS: rd = {2'b00, st_r.xt_ns};
                    tunable_timer_pkg::OFS_XT_SEC: rd = st_r.xt_sec;
                    tunable_timer_pkg::OFS_XT_ARTL: rd = st_r.xt_art[31:0];
                    tunable_timer_pkg::OFS_XT_ARTH: rd = st_r.xt_art[63:32];
                    tunable_timer_pkg::OFS_CMP_LO: rd = {2'b00, st_r.cmp_ns};
                    tunable_timer_pkg::OFS_CMP_HI: rd = st_r.cmp_sec;
                    tunable_timer_pkg::OFS_PIV_LO: rd = {2'b00, st_r.piv_ns};
                    tunable_timer_pkg::OFS_PIV_HI: rd = st_r.piv_sec;
                    tunable_timer_pkg::OFS_VIEW: rd = {26'h0, st_r.view};
                    tunable_timer_pkg::OFS_VIEW_LO: begin
                        // Source chosen by the viewed pin's select
                        if (pc[2:1] == tunable_timer_pkg::SRC_ART) begin
                            rd = st_r.always_running_counter[31:0];
                        end else begin
                            rd = {2'b00, st_r.ns[pc[2:1] - 2'h1]};
                        end
                    end
                    tunable_timer_pkg::OFS_VIEW_HI: begin
                        if (pc[2:1] == tunable_timer_pkg::SRC_ART) begin
                            rd = st_r.always_running_counter[63:32];
                        end else begin
                            rd = st_r.sec[pc[2:1] - 2'h1];
                        end
                    end
                    default: rd = 32'h0;
                endcase
            end
            n.rdata = rd;
        end
        // Set beats clear on the sticky flags
        n.raw = (st_r.raw & ~raw_clr) | raw_set;
        n.irq = |(n.raw & n.mask);
        // Bus phase tracking; reads take one wait state
        case (st_r.bst)
            tunable_timer_pkg::BUS_READ: begin
                n.bst = tunable_timer_pkg::BUS_RDOUT;
            end
            default: begin
                if (hsel && htrans[1] && hready) begin
                    n.addr = haddr[11:0];
                    n.bst = hwrite ? tunable_timer_pkg::BUS_WRITE
                                   : tunable_timer_pkg::BUS_READ;
                end else begin
                    n.bst = tunable_timer_pkg::BUS_IDLE;
                end
            end
        endcase
        st_nxt = n;
    end

    // State register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from registered state
    always_comb begin
        for (int i = 0; i < tunable_timer_pkg::NUM_PINS; i++) begin
            pin_enable[i] = st_r.pinctl[i][tunable_timer_pkg::PC_EN_BIT];
            pin_art_clock[i] = (st_r.pinctl[i][2:1]
                == tunable_timer_pkg::SRC_ART);
        end
    end
    assign hreadyout = !rd_go;
    assign hrdata = st_r.rdata;
    assign hresp = 1'b0;
    assign irq = st_r.irq;

    a_ns_range: assert property (@(posedge clk) disable iff (!resetn)
        st_r.ns[0] <= tunable_timer_pkg::NS_MAX
        && st_r.ns[1] <= tunable_timer_pkg::NS_MAX
        && st_r.ns[2] <= tunable_timer_pkg::NS_MAX)
        else $error("timer ns out of range");
    a_step_bounds: assert property (@(posedge clk) disable iff (!resetn)
        tmr_step(st_r.inc[0], st_r.adj[0] != 30'h0, st_r.adj_neg[0])
            >= tunable_timer_pkg::STEP_MIN
        && tmr_step(st_r.inc[0], st_r.adj[0] != 30'h0, st_r.adj_neg[0])
            <= tunable_timer_pkg::STEP_MAX)
        else $error("timer step outside limits");
    a_adj_drain: assert property (@(posedge clk) disable iff (!resetn)
        st_r.adj[0] != 30'h0 && !(wr_go && st_r.addr
            == tunable_timer_pkg::OFS_ADJ)
        |=> st_r.adj[0] == $past(st_r.adj[0]) - 30'h1)
        else $error("adjust did not drain by one");
    a_adj_replace: assert property (@(posedge clk) disable iff (!resetn)
        wr_go && st_r.addr == tunable_timer_pkg::OFS_ADJ
        |=> st_r.adj[0] == $past(hwdata[29:0]))
        else $error("adjust write not taken");
    a_adj_flag: assert property (@(posedge clk) disable iff (!resetn)
        st_r.adj[1] == 30'h1 && !(wr_go && st_r.addr
            == tunable_timer_pkg::OFS_ADJ + 12'h004)
        |=> st_r.raw[1] ##1 st_r.raw[1] || $past(wr_go))
        else $error("adjust completion flag missing");
    a_snap_latch: assert property (@(posedge clk) disable iff (!resetn)
        rd_go && st_r.addr == tunable_timer_pkg::OFS_SUBNS
        |=> st_r.snap_ns[0] == $past(st_r.ns[0])
            && st_r.snap_sec[0] == $past(st_r.sec[0]))
        else $error("snapshot not latched on fraction read");
    a_snap_valid: assert property (@(posedge clk) disable iff (!resetn)
        wr_go && st_r.addr == tunable_timer_pkg::OFS_SNAPC && hwdata[0]
        |-> ##[1:2] st_r.snap_ok[0])
        else $error("capture never became valid");
    a_one_capture: assert property (@(posedge clk) disable iff (!resetn)
        $onehot0(st_r.snap_ok) && (st_r.snap_ok
            & ~tunable_timer_pkg::SNAP_BITS) == 6'h0)
        else $error("more than one capture valid");
    a_irq_merge: assert property (@(posedge clk) disable iff (!resetn)
        irq == |(st_r.raw & st_r.mask))
        else $error("interrupt not coalesced");
    a_cmp_carry: assert property (@(posedge clk) disable iff (!resetn)
        wr_go && st_r.addr == tunable_timer_pkg::OFS_CMP_LO
        && hwdata[29:0] > tunable_timer_pkg::NS_MAX
        |=> st_r.cmp_sec == $past(st_r.cmp_sec) + 32'h1)
        else $error("compare overflow not carried");
endmodule : tunable_time_base_timer

// [testbench/tb.sv]
`timescale 1ns/1ps
module tb;
    logic clk, resetn, hsel, hwrite, art_tick; // Clock, reset, bus controls
    logic [31:0] haddr, hwdata, hrdata, rd; // Bus words, last read
    logic [1:0] htrans; // Transfer type
    logic hreadyout, hresp, irq; // Slave status
    logic [39:0] pin_enable, pin_art_clock; // Pin outputs
    logic [63:0] v0, v1, e; // Timer snapshots
    int num_errors = 0, num_checks = 0, cyc = 0, t, c1; // Counters
    tunable_time_base_timer tunable_time_base_timer_inst (
        .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .art_tick(art_tick), .pin_enable(pin_enable),
        .pin_art_clock(pin_art_clock), .irq(irq));
    // Free-running 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Cycle count, crystal-rate tick, and a ceiling so a hang still ends
    always @(posedge clk) begin
        cyc <= cyc + 1;
        art_tick <= (cyc % 4 == 0);
        if (cyc == 20000) begin
            num_errors++;
            finish_test();
        end
    end
    task chk(input string n, input logic [31:0] got, input logic [31:0] x);
        num_checks++;
        if (got !== x) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, x, got);
        end
    endtask : chk
    // Address phase held until the slave takes it
    task aph(input logic [11:0] a, input logic w);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
    endtask : aph
    task wr(input logic [11:0] a, input logic [31:0] d);
        aph(a, 1'b1);
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask : wr
    // Read data is taken at the edge that ends the wait
    task rdr(input logic [11:0] a);
        aph(a, 1'b0);
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : rdr
    // Fraction first, so the nanosecond word comes from the same snapshot
    task snap(output logic [63:0] v, output int c);
        rdr(12'h000);
        c = cyc;
        v[31:0] = rd;
        rdr(12'h004);
        v[63:32] = rd;
    endtask : snap
    // Step per tick is 5 ns plus or minus the signed increment
    task rate(input logic [31:0] inc, input logic [63:0] step);
        wr(12'h00c, inc);
        snap(v0, t);
        repeat (20) @(posedge clk);
        snap(v1, c1);
        e = 64'(c1 - t) * step;
        chk("rate_lo", 32'(v1 - v0), e[31:0]);
        chk("rate_hi", 32'((v1 - v0) >> 32), e[63:32]);
        $display("rate test done");
    endtask : rate
    // Counts ticks from the adjust write until the line rises
    task adj(input logic [11:0] a, input logic [31:0] n);
        wr(a, n);
        t = 0;
        while (irq !== 1'b1 && t < 500) begin
            @(posedge clk);
            t++;
        end
    endtask : adj
    task finish_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test
    initial begin
        {hsel, hwrite, haddr, hwdata, htrans} = '0;
        resetn = 1'b0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        chk("pin_en", pin_enable[31:0], 32'h0);
        chk("pin_clk", pin_art_clock[39:8], 32'hffffffff);
        chk("hresp", 32'(hresp), 32'h0);
        rdr(12'h200);
        chk("unmapped", rd, 32'h0);
        $display("reset test done");
        rate(32'h0, 64'h5_0000_0000);
        rate(32'h2000_0000, 64'h5_2000_0000);
        rate(32'ha000_0000, 64'h4_e000_0000);
        // Nanoseconds first, then seconds, close to the wrap
        // Pin 1 stays disabled on timer 1 while its time is set
        wr(12'h104, 32'h4);
        // Wrap lands after the seconds write, so it is not overwritten
        wr(12'h014, 32'h3b9ac9d8);
        wr(12'h018, 32'h5);
        repeat (10) @(posedge clk);
        rdr(12'h010);
        rdr(12'h014);
        chk("wrap_ns", 32'(rd < 32'd64), 32'h1);
        rdr(12'h018);
        chk("wrap_sec", rd, 32'h6);
        $display("wrap test done");
        // Masked completion stays off the line
        adj(12'h030, 32'h4);
        chk("masked_irq", 32'(irq), 32'h0);
        rdr(12'h040);
        chk("raw_adj0", rd & 32'h7, 32'h1);
        wr(12'h040, 32'h1);
        wr(12'h044, 32'h6);
        adj(12'h034, 32'd10);
        chk("adj_time", 32'(t >= 10 && t <= 12), 32'h1);
        wr(12'h040, 32'h2);
        rdr(12'h040);
        chk("raw_clr", rd & 32'h7, 32'h0);
        wr(12'h038, 32'd200);
        adj(12'h038, 32'd3);
        chk("adj_replace", 32'(t >= 3 && t <= 5), 32'h1);
        wr(12'h040, 32'h4);
        $display("adjust test done");
        // Compare word past the last nanosecond carries a second
        wr(12'h074, 32'h0);
        wr(12'h06c, 32'h0);
        wr(12'h068, 32'h3b9aca05);
        rdr(12'h068);
        chk("cmp_ns", rd, 32'h5);
        rdr(12'h06c);
        chk("cmp_sec", rd, 32'h1);
        wr(12'h040, 32'h8);
        wr(12'h044, 32'h8);
        wr(12'h008, 32'h1);
        repeat (3) @(posedge clk);
        chk("cmp_irq", 32'(irq), 32'h1);
        $display("compare test done");
        for (int s = 0; s < 4; s++) begin
            wr(12'h154, 32'(s * 2 + 1));
            @(posedge clk);
            chk("sel_en", 32'(pin_enable[21]), 32'h1);
            chk("sel_clk", 32'(pin_art_clock[21]), 32'(s == 0));
        end
        wr(12'h050, 32'h14);
        repeat (2) @(posedge clk);
        rdr(12'h054);
        chk("snap_one", rd & 32'h15, 32'h4);
        wr(12'h050, 32'h15);
        repeat (2) @(posedge clk);
        rdr(12'h054);
        chk("snap_low", rd & 32'h15, 32'h1);
        $display("pin and snapshot test done");
        finish_test();
    end
endmodule : tb
